// ### heatseal_temp_supervisor.sv
// heatseal temperature supervisor: settings registers, band/heat-up checks, relay.
// assumes avalon-mm master, synchronous inputs, actual temperature from sensor path.
`timescale 1ns/10ps
module heatseal_temp_supervisor
   import heatseal_pkg::*;
#(
   parameter int TENTH_DIV = TENTH_CYCLES
)(
   input wire logic clock,
   input wire logic rst,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [2:0] voltage_switch,
   input wire logic [1:0] current_switch,
   input wire logic start,
   input wire logic fault_ack,
   input wire logic [9:0] set_temp,
   input wire logic [9:0] sensed_temp,
   input wire logic cal_done,
   output logic [9:0] actual_temp,
   output logic fault,
   output logic alarm_relay,
   output logic [1:0] secondary_voltage_range,
   output logic [1:0] secondary_current_range
);
   // elaboration guard: a zero divider would tick only once per 2^32 cycles, so timers would stall
   if (TENTH_DIV < 1)
   begin : g_bad_div
      $error("tenth divider must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // bus slave: one-cycle wait on reads so readdata comes from a flop
   logic rd_done_r, rd_done_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [3:0] reg_idx;
   assign reg_idx = address[5:2];
   assign waitrequest = read & ~rd_done_r;
   assign readdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // settings state
   cfg_s cfg_r, cfg_nxt;
   logic [3:0] lang_r, lang_nxt;
   logic [9:0] cal_off_r, cal_off_nxt;
   logic [1:0] vsel_r, vsel_nxt;
   logic [1:0] isel_r, isel_nxt;
   logic [9:0] err_r, err_nxt;
   logic fault_r, fault_nxt;
   logic [1:0] vdec;
   logic [1:0] idec;

   // switch decode; illegal patterns keep the previous range
   always_comb
   begin
      unique case (voltage_switch)
         3'b001: vdec = 2'h0;
         3'b010: vdec = 2'h1;
         3'b100: vdec = 2'h2;
         default: vdec = 2'h3;
      endcase
      unique case (current_switch)
         2'b00: idec = 2'h0;
         2'b01: idec = 2'h1;
         2'b11: idec = 2'h2;
         default: idec = 2'h3;
      endcase
   end

   // register writes and reads
   always_comb
   begin
      cfg_nxt = cfg_r;
      lang_nxt = lang_r;
      cal_off_nxt = cal_off_r;
      rd_done_nxt = read & ~rd_done_r;
      rdata_nxt = rdata_r;
      vsel_nxt = (vdec == 2'h3) ? vsel_r : vdec;
      isel_nxt = (idec == 2'h3) ? isel_r : idec;
      if (cal_done)
         cal_off_nxt = 10'(cfg_r.cal_temp - sensed_temp);
      if (write)
      begin
         unique case (reg_idx)
            A_LANG: lang_nxt = writedata[3:0];
            A_RESTORE:
               if (writedata[0])
                  cfg_nxt = CFG_DEFAULT;
            A_LEGACY:
               if (writedata[4:0] < LEGACY_CHOICES)
                  cfg_nxt.legacy = writedata[4:0];
            A_ALLOY:
               if (writedata[2:0] <= 3'b101)
                  cfg_nxt.alloy = alloy_e'(writedata[2:0]);
            A_TCR:
               if (cfg_r.alloy == ALLOY_VAR && writedata[11:0] >= TCR_MIN
                   && writedata[11:0] <= TCR_MAX)
                  cfg_nxt.resistance_temp_coefficient = writedata[11:0];
            A_RANGE: cfg_nxt.range = range_e'(writedata[1:0]);
            A_TOL:
            begin
               cfg_nxt.tol_lo = writedata[9:0];
               cfg_nxt.tol_hi = writedata[25:16];
            end
            A_TIMES:
            begin
               if (writedata[6:0] <= DELAY_MAX)
                  cfg_nxt.delay = writedata[6:0];
               cfg_nxt.heatup = writedata[15:8];
            end
            A_ALARM:
            begin
               cfg_nxt.inverse = writedata[0];
               cfg_nxt.diag_en = writedata[1];
            end
            A_CAL: cfg_nxt.cal_temp = writedata[9:0];
            default: ;
         endcase
      end
      if (read & ~rd_done_r)
      begin
         unique case (reg_idx)
            A_LANG: rdata_nxt = {28'h0, lang_r};
            A_LEGACY: rdata_nxt = {27'h0, cfg_r.legacy};
            A_ALLOY: rdata_nxt = {29'h0, cfg_r.alloy};
            A_TCR: rdata_nxt = {20'h0, cfg_r.resistance_temp_coefficient};
            A_RANGE: rdata_nxt = {30'h0, cfg_r.range};
            A_TOL: rdata_nxt = {6'h0, cfg_r.tol_hi, 6'h0, cfg_r.tol_lo};
            A_TIMES: rdata_nxt = {16'h0, cfg_r.heatup, 1'b0, cfg_r.delay};
            A_ALARM: rdata_nxt = {30'h0, cfg_r.diag_en, cfg_r.inverse};
            A_CAL: rdata_nxt = {22'h0, cfg_r.cal_temp};
            A_STATUS: rdata_nxt = {21'h0, fault_r, err_r};
            A_SWITCH: rdata_nxt = {28'h0, isel_r, vsel_r};
            A_ACTUAL: rdata_nxt = {22'h0, actual_temp};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   // language held apart so a restore never touches it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cfg_r <= CFG_DEFAULT;
         lang_r <= 4'h0;
         cal_off_r <= 10'h000;
         rd_done_r <= 1'b0;
         rdata_r <= 32'h0;
         vsel_r <= 2'h0;
         isel_r <= 2'h0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         lang_r <= lang_nxt;
         cal_off_r <= cal_off_nxt;
         rd_done_r <= rd_done_nxt;
         rdata_r <= rdata_nxt;
         vsel_r <= vsel_nxt;
         isel_r <= isel_nxt;
      end
   end
   assign secondary_voltage_range = vsel_r;
   assign secondary_current_range = isel_r;

   ////////////////////////////////////////////////////////////////////////
   // supervision: tenth-second tick, band checks, heat-up timer
   logic [31:0] div_r, div_nxt;
   logic tick;
   sup_e st_r, st_nxt;
   logic [6:0] dly_r, dly_nxt;
   logic [7:0] hup_r, hup_nxt;
   logic hup_run_r, hup_run_nxt;
   logic start_d_r;
   logic [9:0] act_r;
   logic below, above, in_band, reached;
   assign tick = (div_r == 32'(TENTH_DIV - 1));
   assign below = act_r < 10'(set_temp - cfg_r.tol_lo);
   assign above = act_r > 10'(set_temp + cfg_r.tol_hi);
   assign in_band = ~below & ~above;
   assign reached = 20'(act_r) * 20'd100 >= 20'(set_temp) * 20'(PCT_NUM);

   always_comb
   begin
      div_nxt = tick ? 32'h0 : div_r + 32'h1;
      st_nxt = st_r;
      dly_nxt = dly_r;
      hup_nxt = hup_r;
      hup_run_nxt = hup_run_r;
      err_nxt = err_r;
      fault_nxt = fault_r;
      if (fault_ack)
      begin
         fault_nxt = 1'b0;
         err_nxt = 10'h000;
      end
      if (start & ~start_d_r)
      begin
         hup_run_nxt = (cfg_r.heatup != 8'h00);
         hup_nxt = 8'h00;
         st_nxt = cfg_r.diag_en ? SUP_WAIT : SUP_IDLE;
         dly_nxt = 7'h00;
      end
      else if (start)
      begin
         if (hup_run_r)
         begin
            if (reached)
               hup_run_nxt = 1'b0;
            else if (tick)
            begin
               hup_nxt = hup_r + 8'h1;
               if (hup_r + 8'h1 >= cfg_r.heatup)
               begin
                  err_nxt = ERR_HEATUP;
                  fault_nxt = 1'b1;
                  hup_run_nxt = 1'b0;
               end
            end
         end
         unique case (st_r)
            SUP_IDLE: ;
            SUP_WAIT:
               if (in_band)
               begin
                  if (dly_r >= cfg_r.delay)
                     st_nxt = SUP_ARMED;
                  else if (tick)
                     dly_nxt = dly_r + 7'h1;
               end
            SUP_ARMED:
               if (~in_band)
               begin
                  err_nxt = below ? ERR_LOW : ERR_HIGH;
                  fault_nxt = 1'b1;
                  st_nxt = SUP_IDLE;
               end
            default: st_nxt = SUP_IDLE;
         endcase
      end
      else
      begin
         if (st_r == SUP_WAIT)
         begin
            err_nxt = above ? ERR_NOARM_HIGH : ERR_NOARM_LOW;
            fault_nxt = 1'b1;
         end
         st_nxt = SUP_IDLE;
         hup_run_nxt = 1'b0;
      end
   end

   // supervision registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         div_r <= 32'h0;
         st_r <= SUP_IDLE;
         dly_r <= 7'h00;
         hup_r <= 8'h00;
         hup_run_r <= 1'b0;
         err_r <= 10'h000;
         fault_r <= 1'b0;
         start_d_r <= 1'b0;
         act_r <= 10'h000;
      end
      else
      begin
         div_r <= div_nxt;
         st_r <= st_nxt;
         dly_r <= dly_nxt;
         hup_r <= hup_nxt;
         hup_run_r <= hup_run_nxt;
         err_r <= err_nxt;
         fault_r <= fault_nxt;
         start_d_r <= start;
         act_r <= 10'(sensed_temp + cal_off_r);
      end
   end
   assign actual_temp = act_r;
   assign fault = fault_r;
   assign alarm_relay = fault_r ^ cfg_r.inverse;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_relay;
      @(posedge clock) disable iff (rst) alarm_relay == (cfg_r.inverse ? ~fault : fault);
   endproperty
   a_relay: assert property (p_relay) else $error("relay polarity wrong");
   property p_ack;
      @(posedge clock) disable iff (rst) fault_ack |=> ~fault | $rose(fault);
   endproperty
   a_ack: assert property (p_ack) else $error("ack ignored");
   property p_stop;
      @(posedge clock) disable iff (rst) ~start |=> st_r == SUP_IDLE && ~hup_run_r;
   endproperty
   a_stop: assert property (p_stop) else $error("not idle after stop");
   // band exit while armed in a running cycle, not masked by an operator reset
   sequence s_band_exit;
      start && start_d_r && st_r == SUP_ARMED && ~in_band && ~fault_ack;
   endsequence
   property p_armed_leave;
      @(posedge clock) disable iff (rst) s_band_exit |=> fault;
   endproperty
   a_armed_leave: assert property (p_armed_leave) else $error("band exit missed");
   property p_noarm;
      @(posedge clock) disable iff (rst)
         ~start && st_r == SUP_WAIT |=> fault && err_r >= ERR_NOARM_LOW;
   endproperty
   a_noarm: assert property (p_noarm) else $error("no-arm fault missed");
   property p_tcr;
      @(posedge clock) disable iff (rst) cfg_r.alloy != ALLOY_VAR |=> $stable(cfg_r.resistance_temp_coefficient) ||
         $past(write) && $past(reg_idx) == A_RESTORE;
   endproperty
   a_tcr: assert property (p_tcr) else $error("tcr changed while locked");
   property p_lang;
      @(posedge clock) disable iff (rst) write && reg_idx == A_RESTORE |=> $stable(lang_r);
   endproperty
   a_lang: assert property (p_lang) else $error("restore hit language");
   property p_arm;
      @(posedge clock) disable iff (rst)
         st_r == SUP_WAIT && start && start_d_r && in_band && dly_r >= cfg_r.delay
         |=> st_r == SUP_ARMED;
   endproperty
   a_arm: assert property (p_arm) else $error("did not arm");
endmodule // heatseal_temp_supervisor

// ### heatseal_pkg.sv
// package for the heatseal temperature supervisor: settings, defaults, timing.
// assumes a 100 MHz clock and temperatures in whole kelvin/degrees, 10-bit.
// Functional notes
// - decode one-hot voltage range switches and two current range switches
// - language can change at any time without disturbing heating or supervision
// - factory restore resets all settings except the language
// - legacy combined coefficient/range choice has 18 entries, default 1100 ppm 0-300
// - alloy choice 780/1100/1400/1700/3500/variable, default 1100 ppm
// - free coefficient 400-4000 ppm only writable when alloy is variable
// - range limit only 200/300/400/500, default 300
// - independent lower/upper tolerance offsets, defaults -10 K and +10 K
// - diagnosis arms when actual is inside band while start is active
// - armed and actual leaves band gives 307 (low) or 308 (high) and fault
// - start falls before arming gives 309 or 310 and fault
// - delay 0-9.9 s after first lower-limit crossing withholds arming
// - heat-up timer starts with start; zero setting disables it
// - below 95 percent of set after heat-up time gives 304 and fault
// - alarm relay polarity: normal closes on fault, inverse opens on fault
// - after zero calibration actual shows calibration temperature, default 20
// - operator reset acknowledges faults and returns to normal indication
package heatseal_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int TENTH_S_NS = 100_000_000;
   localparam int CLK_NS = 10;
   localparam int TENTH_CYCLES = TENTH_S_NS / CLK_NS;
   localparam logic [4:0] LEGACY_CHOICES = 5'h12;
   localparam logic [4:0] LEGACY_DEFAULT = 5'h0d;
   localparam logic [11:0] TCR_MIN = 12'h190;
   localparam logic [11:0] TCR_MAX = 12'hfa0;
   localparam logic [11:0] TCR_DEFAULT = 12'h44c;
   localparam logic [6:0] DELAY_MAX = 7'h63;
   localparam logic [9:0] TOL_DEFAULT = 10'h00a;
   localparam logic [9:0] CAL_TEMP_DEFAULT = 10'h014;
   localparam logic [9:0] PCT_NUM = 10'h05f;
   localparam logic [9:0] ERR_HEATUP = 10'h130;
   localparam logic [9:0] ERR_LOW = 10'h133;
   localparam logic [9:0] ERR_HIGH = 10'h134;
   localparam logic [9:0] ERR_NOARM_LOW = 10'h135;
   localparam logic [9:0] ERR_NOARM_HIGH = 10'h136;
   typedef enum logic [2:0] {
      ALLOY_780 = 3'b000, ALLOY_1100 = 3'b001, ALLOY_1400 = 3'b010,
      ALLOY_1700 = 3'b011, ALLOY_3500 = 3'b100, ALLOY_VAR = 3'b101
   } alloy_e;
   typedef enum logic [1:0] {
      RANGE_200 = 2'b00, RANGE_300 = 2'b01, RANGE_400 = 2'b10, RANGE_500 = 2'b11
   } range_e;
   typedef enum logic [1:0] {
      SUP_IDLE = 2'b00, SUP_WAIT = 2'b01, SUP_ARMED = 2'b10
   } sup_e;
   typedef struct packed {
      logic [4:0] legacy;
      alloy_e alloy;
      logic [11:0] resistance_temp_coefficient;
      range_e range;
      logic [9:0] tol_lo;
      logic [9:0] tol_hi;
      logic [6:0] delay;
      logic [7:0] heatup;
      logic inverse;
      logic diag_en;
      logic [9:0] cal_temp;
   } cfg_s;
   localparam cfg_s CFG_DEFAULT = '{legacy: LEGACY_DEFAULT, alloy: ALLOY_1100,
      resistance_temp_coefficient: TCR_DEFAULT, range: RANGE_300, tol_lo: TOL_DEFAULT, tol_hi: TOL_DEFAULT,
      delay: 7'h00, heatup: 8'h00, inverse: 1'b0, diag_en: 1'b0,
      cal_temp: CAL_TEMP_DEFAULT};
   localparam logic [3:0] A_LANG = 4'h0;
   localparam logic [3:0] A_RESTORE = 4'h1;
   localparam logic [3:0] A_LEGACY = 4'h2;
   localparam logic [3:0] A_ALLOY = 4'h3;
   localparam logic [3:0] A_TCR = 4'h4;
   localparam logic [3:0] A_RANGE = 4'h5;
   localparam logic [3:0] A_TOL = 4'h6;
   localparam logic [3:0] A_TIMES = 4'h7;
   localparam logic [3:0] A_ALARM = 4'h8;
   localparam logic [3:0] A_CAL = 4'h9;
   localparam logic [3:0] A_STATUS = 4'ha;
   localparam logic [3:0] A_SWITCH = 4'hb;
   localparam logic [3:0] A_ACTUAL = 4'hc;
endpackage

// ### machine_side_model.sv
// machine side: start line, band temperature and operator reset key.
// assumes the bench sets the request lines; contact state is reported back.
`timescale 1ns/10ps
module machine_side_model
   import heatseal_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start_req,
   input wire logic [9:0] temp_req,
   input wire logic ack_req,
   input wire logic alarm_relay,
   output logic start,
   output logic [9:0] sensed_temp,
   output logic fault_ack,
   output logic contact_closed
);
   // requests land one edge late, as on a real machine line
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         start <= 1'b0;
         fault_ack <= 1'b0;
      end
      else
      begin
         start <= start_req;
         fault_ack <= ack_req;
      end
      sensed_temp <= temp_req;
   end
   assign contact_closed = alarm_relay;
endmodule // machine_side_model

// ### heatseal_temp_supervisor_tb.sv
// bench for the heatseal supervisor: settings, switches, diagnosis, heat-up.
// assumes the machine side model drives start, band temperature and reset key.
`timescale 1ns/10ps
module heatseal_temp_supervisor_tb
   import heatseal_pkg::*;
;
   logic clock, rst, read, write, cal_done, start_req, ack_req, start, fault_ack;
   logic waitrequest, fault, alarm_relay, contact_closed;
   logic [5:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [2:0] voltage_switch;
   logic [1:0] current_switch, secondary_voltage_range, secondary_current_range;
   logic [9:0] set_temp, temp_req, sensed_temp, actual_temp;
   int mismatches = 0;
   int n_tests = 0;
   // short tenth-second divider keeps delay and heat-up counts small
   heatseal_temp_supervisor #(.TENTH_DIV(4)) heatseal_temp_supervisor_i (.clock(clock),
      .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .voltage_switch(voltage_switch),
      .current_switch(current_switch), .start(start), .fault_ack(fault_ack),
      .set_temp(set_temp), .sensed_temp(sensed_temp), .cal_done(cal_done),
      .actual_temp(actual_temp), .fault(fault), .alarm_relay(alarm_relay),
      .secondary_voltage_range(secondary_voltage_range),
      .secondary_current_range(secondary_current_range));
   machine_side_model machine_side_model_i (.clock(clock), .rst(rst),
      .start_req(start_req), .temp_req(temp_req), .ack_req(ack_req),
      .alarm_relay(alarm_relay), .start(start), .sensed_temp(sensed_temp),
      .fault_ack(fault_ack), .contact_closed(contact_closed));
   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic give_verdict();
      $display("counts: %0d compared, %0d mismatched", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // sample between edges so registered outputs have settled
   task automatic look(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // one avalon transfer; request held until waitrequest is sampled low at a rising edge,
   // read data taken at that same edge, release only afterwards
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
      int n;
      @(posedge clock);
      address <= {idx, 2'b00};
      writedata <= d;
      write <= wr;
      read <= ~wr;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0)
      begin
         chk(32'h1, 32'h0);
         give_verdict();
      end
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask
   // bounded wait; a limit that runs out shows up as a mismatch
   task automatic wait_fault(input logic exp);
      int n;
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (fault !== exp && n < 80);
      chk(fault, exp);
      if (fault !== exp)
         give_verdict();
   endtask
   task automatic clear();
      tick(1);
      start_req <= 1'b0;
      temp_req <= 10'h0c8;
      ack_req <= 1'b1;
      tick(1);
      ack_req <= 1'b0;
      wait_fault(1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_defaults();
      logic [3:0] idx [9] = '{A_LEGACY, A_ALLOY, A_TCR, A_RANGE, A_TOL, A_TIMES, A_ALARM,
         A_CAL, 4'hf};
      logic [31:0] exp [9] = '{32'h0d, 32'h1, 32'h44c, 32'h1, 32'h000a000a, 32'h0, 32'h0,
         32'h14, 32'h0};
      foreach (idx[i])
         rdchk(idx[i], exp[i]);
      look(0);
      chk(alarm_relay, 1'b0);
      $display("done: defaults");
   endtask
   task automatic t_switches();
      logic [1:0] cur [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
      logic [1:0] cexp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
      for (int i = 0; i < 4; i++)
      begin
         tick(1);
         voltage_switch <= (i == 3) ? 3'b011 : 3'b001 << i;
         current_switch <= cur[i];
         look(2);
         chk(secondary_voltage_range, (i == 3) ? 2'h2 : i[1:0]);
         chk(secondary_current_range, cexp[i]);
      end
      rdchk(A_SWITCH, 32'ha);
      $display("done: switches");
   endtask
   task automatic t_coeff();
      bus(1'b1, A_TCR, 32'h7d0);
      rdchk(A_TCR, 32'h44c);
      for (int i = 6; i >= 0; i--)
      begin
         bus(1'b1, A_ALLOY, i);
         rdchk(A_ALLOY, (i == 6) ? 32'h1 : i);
      end
      bus(1'b1, A_ALLOY, 32'h5);
      bus(1'b1, A_TCR, 32'hfa1);
      rdchk(A_TCR, 32'h44c);
      bus(1'b1, A_TCR, 32'h190);
      rdchk(A_TCR, 32'h190);
      bus(1'b1, A_LEGACY, 32'h12);
      rdchk(A_LEGACY, 32'h0d);
      bus(1'b1, A_LEGACY, 32'h11);
      rdchk(A_LEGACY, 32'h11);
      bus(1'b1, A_RANGE, 32'h3);
      rdchk(A_RANGE, 32'h3);
      $display("done: coefficient");
   endtask
   // start cycle: band temperature t0, then t1, then start dropped
   task automatic diag_case(input logic [9:0] t0, input logic [9:0] t1,
      input logic [9:0] err);
      tick(1);
      temp_req <= t0;
      start_req <= 1'b1;
      tick(12);
      temp_req <= t1;
      tick(12);
      start_req <= 1'b0;
      wait_fault(1'b1);
      chk(alarm_relay, 1'b1);
      rdchk(A_STATUS, {21'h0, 1'b1, err});
      clear();
   endtask
   task automatic t_diag();
      bus(1'b1, A_ALARM, 32'h2);
      diag_case(10'h0c8, 10'h0d7, ERR_HIGH);
      diag_case(10'h0c8, 10'h0b9, ERR_LOW);
      diag_case(10'h096, 10'h096, ERR_NOARM_LOW);
      diag_case(10'h0e6, 10'h0e6, ERR_NOARM_HIGH);
      // asymmetric band 195..220: only independent offsets give these codes
      bus(1'b1, A_TOL, 32'h00140005);
      rdchk(A_TOL, 32'h00140005);
      diag_case(10'h0dc, 10'h0dd, ERR_HIGH);
      diag_case(10'h0c3, 10'h0c2, ERR_LOW);
      bus(1'b1, A_TIMES, 32'h32);
      diag_case(10'h0c8, 10'h0b9, ERR_NOARM_LOW);
      $display("done: diagnosis");
   endtask
   task automatic t_heatup();
      bus(1'b1, A_ALARM, 32'h1);
      look(1);
      chk(alarm_relay, 1'b1);
      bus(1'b1, A_TIMES, 32'h200);
      temp_req <= 10'h064;
      start_req <= 1'b1;
      wait_fault(1'b1);
      chk(contact_closed, 1'b0);
      rdchk(A_STATUS, {21'h0, 1'b1, ERR_HEATUP});
      clear();
      tick(1);
      temp_req <= 10'h0be;
      start_req <= 1'b1;
      look(40);
      chk(fault, 1'b0);
      clear();
      bus(1'b1, A_TIMES, 32'h0);
      temp_req <= 10'h064;
      start_req <= 1'b1;
      bus(1'b1, A_LANG, 32'h3);
      look(60);
      chk(fault, 1'b0);
      clear();
      $display("done: heat-up");
   endtask
   task automatic t_restore();
      bus(1'b1, A_RESTORE, 32'h1);
      t_defaults();
      rdchk(A_LANG, 32'h3);
      temp_req <= 10'h025;
      tick(2);
      cal_done <= 1'b1;
      tick(1);
      cal_done <= 1'b0;
      look(3);
      chk(actual_temp, CAL_TEMP_DEFAULT);
      // a non-default calibration temperature must show up the same way
      bus(1'b1, A_CAL, 32'h19);
      rdchk(A_CAL, 32'h19);
      cal_done <= 1'b1;
      tick(1);
      cal_done <= 1'b0;
      look(3);
      chk(actual_temp, 10'h019);
      rdchk(A_ACTUAL, 32'h19);
      $display("done: restore and calibration");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // all inputs defined at time zero, reset held six cycles
   initial
   begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0;
      cal_done = 1'b0;
      start_req = 1'b0;
      ack_req = 1'b0;
      voltage_switch = 3'b000;
      current_switch = 2'b00;
      set_temp = 10'h0c8;
      temp_req = 10'h0c8;
      tick(6);
      rst <= 1'b0;
      t_defaults();
      t_switches();
      t_coeff();
      t_diag();
      t_heatup();
      t_restore();
      give_verdict();
   end
endmodule // heatseal_temp_supervisor_tb
